// >>> hdl/flash_bus_host.sv
`timescale 1ns/1ps
// host-side controller driving the parallel flash pins
module flash_bus_host #(
  parameter int ADDR_W = flash_host_pkg::ADDR_W,
  parameter int DATA_W = flash_host_pkg::DATA_W
) (
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  // user request side
  input  wire logic              req_valid_in,
  input  wire logic [1:0]        req_op_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  input  wire logic              boost_req_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_rdata_out,
  output logic [6:0]             rsp_sector_out,
  // flash pins
  output logic [ADDR_W-1:0]      flash_addr_out,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe_out,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_sel_n_out,
  output logic                   flash_gate_n_out,
  output logic                   flash_wstrobe_n_out,
  output logic                   flash_reset_n_out,
  output logic                   program_boost_pin_out
);
  typedef flash_host_pkg::bus_state_t st_t;
  st_t                     state_r, state_nxt;
  logic [ADDR_W-1:0]       addr_r;
  logic [DATA_W-1:0]       wdata_r, rdata_r;
  logic [DATA_W-1:0]       dq_s1_r, dq_s2_r;
  logic                    page_valid_r;
  logic                    rsp_valid_r;
  logic                    boost_r;
  logic                    tmr_load;
  logic [flash_host_pkg::CNT_W-1:0] tmr_count;
  logic                    tmr_done;
  logic                    same_page;
  logic                    take_req;
  logic [flash_host_pkg::CNT_W-1:0] read_wait;
  logic                    rst_arm_r;
  logic [flash_host_pkg::CNT_W-1:0] rst_low_cnt_r;

  // extra two cycles cover the data synchroniser
  localparam logic [flash_host_pkg::CNT_W-1:0] SYNC_CYC = 8'h02;

  flash_wait_timer #(.W(flash_host_pkg::CNT_W)) u_timer (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .load_in    (tmr_load),
    .count_in   (tmr_count),
    .done_out   (tmr_done)
  );

  // page hit only while select stays low and upper bits match
  assign same_page = page_valid_r &&
    (req_addr_in[ADDR_W-1:flash_host_pkg::PAGE_LSB] ==
     addr_r[ADDR_W-1:flash_host_pkg::PAGE_LSB]); // see RL4 see RL22
  assign read_wait = same_page ? flash_host_pkg::CNT_W'(flash_host_pkg::PAGE_CYC) + SYNC_CYC
                               : flash_host_pkg::CNT_W'(flash_host_pkg::SEL_CYC) + SYNC_CYC; // see RL5 see RL14
  assign req_ready_out = (state_r == flash_host_pkg::ST_IDLE);
  assign take_req      = req_valid_in && req_ready_out;

  // next state and timer loads
  always_comb begin
    state_nxt = state_r;
    tmr_load  = 1'b0;
    tmr_count = '0;
    case (state_r)
      flash_host_pkg::ST_RESET: begin
        if (rst_arm_r) begin
          // power-up pulse gets the full width as well
          tmr_load  = 1'b1;
          tmr_count = flash_host_pkg::CNT_W'(flash_host_pkg::RST_CYC - 1); // see RL18
        end else if (tmr_done) begin
          state_nxt = flash_host_pkg::ST_IDLE; // requests wait for the pulse end, see RL19
        end
      end
      flash_host_pkg::ST_IDLE: begin
        if (take_req) begin
          tmr_load = 1'b1;
          case (req_op_in)
            flash_host_pkg::OP_READ: begin
              state_nxt = flash_host_pkg::ST_READ;
              tmr_count = read_wait;
            end
            flash_host_pkg::OP_WRITE: begin
              state_nxt = flash_host_pkg::ST_WRITE;
              tmr_count = flash_host_pkg::CNT_W'(flash_host_pkg::WE_CYC); // write strobe low for WE_CYC plus one cycles, see RL7
            end
            default: begin
              state_nxt = flash_host_pkg::ST_RESET;
              // counter holds state one cycle past its load value
              tmr_count = flash_host_pkg::CNT_W'(flash_host_pkg::RST_CYC - 1); // see RL18
            end
          endcase
        end
      end
      flash_host_pkg::ST_READ: begin
        if (tmr_done) begin
          state_nxt = flash_host_pkg::ST_IDLE;
        end
      end
      flash_host_pkg::ST_WRITE: begin
        if (tmr_done) begin
          state_nxt = flash_host_pkg::ST_RECOVER;
          tmr_load  = 1'b1;
          tmr_count = flash_host_pkg::CNT_W'(flash_host_pkg::REC_CYC);
        end
      end
      flash_host_pkg::ST_RECOVER: begin
        if (tmr_done) begin
          state_nxt = flash_host_pkg::ST_IDLE;
        end
      end
      default: state_nxt = flash_host_pkg::ST_IDLE;
    endcase
  end

  // state and request capture
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_r   <= flash_host_pkg::ST_RESET;
      rst_arm_r <= 1'b1;
      addr_r    <= '0;
      wdata_r   <= '0;
    end else begin
      state_r   <= state_nxt;
      rst_arm_r <= 1'b0;
      if (take_req) begin
        addr_r  <= req_addr_in;
        wdata_r <= req_wdata_in;
      end
    end
  end

  // page tracking; any non-read or select release forgets the page
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      page_valid_r <= 1'b0;
    end else if (state_r == flash_host_pkg::ST_READ && tmr_done) begin
      page_valid_r <= 1'b1;
    end else if (take_req && req_op_in != flash_host_pkg::OP_READ) begin
      page_valid_r <= 1'b0; // see RL5
    end
  end

  // data pins come from another domain, two flops first
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // read capture once access time has elapsed
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rdata_r     <= '0;
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= (state_r == flash_host_pkg::ST_READ) && tmr_done;
      if ((state_r == flash_host_pkg::ST_READ) && tmr_done) begin
        rdata_r <= dq_s2_r;
      end
    end
  end

  // boost only honoured while idle, writing or recovering; reads and reset pulses drop it
  // in the same cycle, since high voltage outside programming harms the part
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      boost_r <= 1'b0;
    end else begin
      boost_r <= boost_req_in &&
                 (state_nxt != flash_host_pkg::ST_RESET) &&
                 (state_nxt != flash_host_pkg::ST_READ); // see RL10 see RL11
    end
  end

  // length of each flash reset pulse, for the width check below
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || flash_reset_n_out) begin
      rst_low_cnt_r <= '0;
    end else if (rst_low_cnt_r != '1) begin
      rst_low_cnt_r <= rst_low_cnt_r + 1'b1;
    end
  end

  assign rsp_valid_out  = rsp_valid_r;
  assign rsp_rdata_out  = rdata_r;
  assign rsp_sector_out = addr_r[ADDR_W-1:flash_host_pkg::SECT_LSB]; // see RL21
  assign flash_addr_out = addr_r;
  assign flash_dq_out   = wdata_r;
  // pin strobes decoded from state; select also from page_valid_r
  assign flash_sel_n_out     = !(state_r == flash_host_pkg::ST_READ ||
                                 state_r == flash_host_pkg::ST_WRITE ||
                                 (state_r == flash_host_pkg::ST_IDLE && page_valid_r)); // see RL1
  assign flash_gate_n_out    = (state_r != flash_host_pkg::ST_READ); // see RL1 see RL6
  assign flash_wstrobe_n_out = (state_r != flash_host_pkg::ST_WRITE); // see RL6
  assign flash_dq_oe_out     = (state_r == flash_host_pkg::ST_WRITE) ||
                               (state_r == flash_host_pkg::ST_RECOVER);
  assign flash_reset_n_out   = (state_r != flash_host_pkg::ST_RESET); // see RL18 see RL2
  assign program_boost_pin_out = boost_r;

  // never drive and read at once
  a_no_contention: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL6
    !(flash_dq_oe_out && !flash_gate_n_out)) else $error("bus contention");
  a_read_strobes: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL1
    !flash_gate_n_out |-> (!flash_sel_n_out && flash_wstrobe_n_out))
    else $error("bad read strobes");
  a_write_strobes: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL6
    !flash_wstrobe_n_out |-> (!flash_sel_n_out && flash_gate_n_out))
    else $error("bad write strobes");
  a_reset_width: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL18
    $fell(flash_reset_n_out) |-> !flash_reset_n_out [*8])
    else $error("reset pulse short");
  // whole pulse measured by the helper counter, too long for a repetition
  a_reset_full_width: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL18
    $rose(flash_reset_n_out) |->
      (rst_low_cnt_r >= flash_host_pkg::CNT_W'(flash_host_pkg::RST_CYC)))
    else $error("reset pulse below minimum width");
  a_page_read_time: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL5
    $fell(flash_gate_n_out) |-> !flash_gate_n_out [*5])
    else $error("in-page read too short");
  a_write_pulse: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL6
    $fell(flash_wstrobe_n_out) |-> !flash_wstrobe_n_out [*7])
    else $error("write pulse short");
  a_read_response: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL3
    $rose(flash_gate_n_out) && state_r == flash_host_pkg::ST_IDLE |-> rsp_valid_out)
    else $error("read response missing");
  a_boost_quiet: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL11
    !flash_reset_n_out |-> !program_boost_pin_out)
    else $error("boost during reset");
  a_boost_read_quiet: assert property (@(posedge sys_clk_in) disable iff (reset_in) // see RL11
    !flash_gate_n_out |-> !program_boost_pin_out)
    else $error("boost during read");
endmodule

// >>> hdl/flash_host_pkg.sv
// Overview of operation
// RL1 - reads drive select and output gate low, write strobe stays high
// RL2 - device starts in array read after power-up or hardware reset
// RL3 - array data returns until a written command changes mode
// RL4 - four-word page; upper bits pick page, two low bits pick word
// RL5 - first access waits full time; in-page accesses wait short time
// RL6 - writes drive write strobe and select low, output gate high
// RL7 - unlock-bypass program takes two write cycles instead of four
// RL8 - erase may cover one sector, several sectors, or whole array
// RL9 - buffered programming accepts at most sixteen words
// RL10 - boost level enters unlock-bypass and allows two-cycle program
// RL11 - boost removed restores normal mode; boost only while accelerated programming (host also drives boost while idle if requested)
// RL12 - identification reads return codes on low data byte, normal timing
// RL13 - select and reset high give standby with outputs high impedance
// RL14 - leaving standby, data valid only after full select access time
// RL15 - deselecting during program or erase does not abort it
// RL16 - automatic sleep after address stable for access time plus 30 ns
// RL17 - sleep keeps output data latched; new address uses normal timing
// RL18 - reset pulse of minimum width aborts operation and returns array read
// RL19 - host restarts an operation that a reset aborted
// RL20 - output gate high puts data pins in high impedance
// RL21 - sector decoded from address bits 21 down to 15
// RL22 - short in-page delay only while page and select unchanged
package flash_host_pkg;
  localparam int CLK_PERIOD_PS        = 5000;
  localparam int ADDR_ACCESS_TIME_PS  = 90000;
  localparam int SELECT_ACCESS_PS     = 90000;
  localparam int IN_PAGE_ACCESS_PS    = 25000;
  localparam int RESET_PULSE_WIDTH_PS = 500000;
  localparam int WRITE_PULSE_PS       = 35000;
  localparam int RECOVERY_PS          = 20000;
  // least times round up to whole cycles
  localparam int ACC_CYC   = (ADDR_ACCESS_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SEL_CYC   = (SELECT_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PAGE_CYC  = (IN_PAGE_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_CYC   = (RESET_PULSE_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WE_CYC    = (WRITE_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REC_CYC   = (RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ADDR_W    = 22;
  localparam int DATA_W    = 16;
  localparam int PAGE_LSB  = 2;
  localparam int SECT_LSB  = 15;
  localparam int CNT_W     = 8;
  localparam int ID_W      = 8;
  localparam int MAX_BUF_WORDS = 16;
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RESET = 2'h2;
  typedef enum logic [2:0] {
    ST_RESET, ST_IDLE, ST_READ, ST_WRITE, ST_RECOVER
  } bus_state_t;
endpackage

// >>> hdl/flash_wait_timer.sv
`timescale 1ns/1ps
// loadable down counter; done is high when count reaches zero
module flash_wait_timer #(
  parameter int W = 8
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign cnt_nxt  = load_in ? count_in : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  // no load term here: the state machine reloads on done, which would loop
  assign done_out = (cnt_r == '0);

  // counter register
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// >>> tb/flash_dev_model.sv
`timescale 1ns/1ps
// behavioural flash device; delays counted in host clock cycles
module flash_dev_model (
  input  wire logic        clk_in,
  input  wire logic [21:0] addr_in,
  input  wire logic [15:0] dq_in,
  input  wire logic        sel_n_in,
  input  wire logic        gate_n_in,
  input  wire logic        wstrobe_n_in,
  input  wire logic        reset_n_in,
  output logic      [15:0] dq_out
);
  logic [15:0] mem [int];
  logic [21:0] addr_r;
  logic [15:0] last_r = 16'h0000;
  logic        seln_r;
  logic        wr_r;
  logic        wr_on;
  logic        live;
  int          wait_r;
  // unwritten words read an address pattern, no command needed
  function automatic logic [15:0] word(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : a[15:0] ^ 16'hA5A5;
  endfunction
  // access timer: page or select change costs full time, in-page short;
  // a change is seen one edge late, so each count starts one lower
  always @(posedge clk_in) begin
    addr_r <= addr_in;
    seln_r <= sel_n_in;
    wr_r   <= wr_on;
    if (sel_n_in || seln_r || !reset_n_in || addr_in[21:2] != addr_r[21:2]) begin
      wait_r <= flash_host_pkg::ACC_CYC - 1;
    end else if (addr_in[1:0] != addr_r[1:0]) begin
      wait_r <= flash_host_pkg::PAGE_CYC - 1;
    end else if (wait_r > 0) begin
      wait_r <= wait_r - 1; // stable address: data stays latched
    end
    if (live) begin
      last_r <= word(addr_in);
    end
    // word taken when select or strobe rises, whichever is first; it then
    // completes whatever select does, and a reset pulse ignores writes
    if (wr_r && !wr_on && reset_n_in) begin
      mem[addr_in] = dq_in;
    end
  end
  // released pins show the inverse so a stale value never passes
  always_comb begin
    wr_on = reset_n_in && !sel_n_in && !wstrobe_n_in && gate_n_in;
    live = reset_n_in && !sel_n_in && !gate_n_in && wstrobe_n_in && wait_r == 0;
    dq_out = live ? word(addr_in) : ~last_r;
  end
endmodule

// >>> tb/test_flash_bus_host.sv
`timescale 1ns/1ps
// runs the flash host against the behavioural device
module test_flash_bus_host;
  logic        sys_clk_in, reset_in, req_valid_in, boost_req_in;
  logic [1:0]  req_op_in;
  logic [21:0] req_addr_in, flash_addr_out, a;
  logic [15:0] req_wdata_in, rsp_rdata_out, flash_dq_out, dev_dq, dq_wire;
  logic        req_ready_out, rsp_valid_out, flash_dq_oe_out, flash_sel_n_out;
  logic        flash_gate_n_out, flash_wstrobe_n_out, flash_reset_n_out, program_boost_pin_out;
  logic [6:0]  rsp_sector_out;
  logic [22:0] exp_q [$];
  logic [15:0] shadow [int];
  int          err_total, compares, l0, l1, n;
  assign dq_wire = flash_dq_oe_out ? flash_dq_out : dev_dq;
  flash_bus_host uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .boost_req_in(boost_req_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_rdata_out(rsp_rdata_out), .rsp_sector_out(rsp_sector_out),
    .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out), .flash_dq_in(dq_wire), .flash_sel_n_out(flash_sel_n_out),
    .flash_gate_n_out(flash_gate_n_out), .flash_wstrobe_n_out(flash_wstrobe_n_out),
    .flash_reset_n_out(flash_reset_n_out), .program_boost_pin_out(program_boost_pin_out));
  flash_dev_model dev (.clk_in(sys_clk_in), .addr_in(flash_addr_out), .dq_in(dq_wire),
    .sel_n_in(flash_sel_n_out), .gate_n_in(flash_gate_n_out),
    .wstrobe_n_in(flash_wstrobe_n_out), .reset_n_in(flash_reset_n_out), .dq_out(dev_dq));
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // request held from a falling edge until the rising edge that takes it
  task automatic req(input logic [1:0] op, input logic [21:0] ad, input logic [15:0] d);
    int k;
    @(negedge sys_clk_in);
    req_valid_in = 1'b1;
    req_op_in = op;
    req_addr_in = ad;
    req_wdata_in = d;
    for (k = 0; req_ready_out !== 1'b1 && k < 500; k++) @(negedge sys_clk_in);
    chk("request taken", 1'b1, req_ready_out);
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
  endtask
  task automatic wr(input logic [21:0] ad, input logic [15:0] d);
    shadow[ad] = d;
    req(flash_host_pkg::OP_WRITE, ad, d);
  endtask
  // read noted in the queue; returns cycles until its answer
  task automatic rd(input logic [21:0] ad, output int lat);
    exp_q.push_back({ad[21:15], shadow.exists(ad) ? shadow[ad] : ad[15:0] ^ 16'hA5A5});
    req(flash_host_pkg::OP_READ, ad, 16'h0000);
    for (lat = 0; exp_q.size() != 0 && lat < 500; lat++) @(negedge sys_clk_in);
    chk("read answers pending", 23'h0, 23'(exp_q.size()));
  endtask
  // answers and strobe levels watched at the falling edge, where they are settled
  always @(negedge sys_clk_in) begin
    if (rsp_valid_out === 1'b1) begin
      if (exp_q.size() == 0) chk("spare answer", 23'h0, 23'h1);
      else chk("read answer", exp_q.pop_front(), {rsp_sector_out, rsp_rdata_out});
    end
    if (flash_gate_n_out === 1'b0) begin
      chk("read strobes", 3'h2, {flash_sel_n_out, flash_wstrobe_n_out, flash_dq_oe_out});
      chk("boost in read", 1'b0, program_boost_pin_out);
    end
    if (flash_wstrobe_n_out === 1'b0) begin
      chk("write strobes", 2'h1, {flash_sel_n_out, flash_gate_n_out});
    end
  end
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  initial begin
    {req_valid_in, boost_req_in, req_op_in, req_addr_in, req_wdata_in} = '0;
    reset_in = 1'b1;
    void'($urandom(32'hC39D8162));
    repeat (4) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    reset_in = 1'b0;
    for (n = 0; n < 3; n++) rd($urandom, l0);
    rd(22'h3FFFFF, l0);
    $display("test power-up reads done");
    for (n = 0; n < 4; n++) begin
      a = $urandom;
      wr(a, $urandom);
      rd(a, l0);
    end
    $display("test write readback done");
    a = $urandom;
    for (n = 0; n < flash_host_pkg::MAX_BUF_WORDS; n++) wr(a + n, $urandom);
    for (n = 0; n < flash_host_pkg::MAX_BUF_WORDS; n++) rd(a + n, l0);
    $display("test sixteen word burst done");
    a = {$urandom, 2'h0};
    rd(a, l0);
    for (n = 1; n < 4; n++) begin
      rd(a | n, l1);
      chk("in-page faster", 1'b1, l1 < l0);
    end
    wr(a ^ 22'h4, 16'h1234);
    rd(a | 22'h1, l1);
    chk("page lost after write", 1'b1, l1 > l0 - 3);
    $display("test page reads done");
    for (n = 2; n < 4; n++) begin
      req(n[1:0], 22'h0, 16'h0000);
      for (l0 = 0; flash_reset_n_out !== 1'b0 && l0 < 50; l0++) @(negedge sys_clk_in);
      for (l1 = 0; flash_reset_n_out === 1'b0 && l1 < 500; l1++) @(negedge sys_clk_in);
      chk("reset pulse width", flash_host_pkg::RST_CYC, l1);
      rd(a | 22'h1, l0);
    end
    $display("test reset pulse done");
    @(negedge sys_clk_in);
    boost_req_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    chk("boost on", 1'b1, program_boost_pin_out);
    a = $urandom;
    wr(a, $urandom);
    rd(a, l0);
    boost_req_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    chk("boost off", 1'b0, program_boost_pin_out);
    $display("test boost done");
    give_verdict();
  end
endmodule
